/* File: rtl/adr_regs.sv */
// Overview of operation
// - reg 13 holds fast code, divider high bits
// - fast code maps to ratios 4,5,6,7,9,11
// - fast divider counts controlled oscillator edges
// - output divider field is ratio minus one
// - ratio one or even up to 128
// - reg 14 holds divider low bits, word top
// - reg 15 holds reference word bits 31:24
// - reference word drives the controlled oscillator
// - regs 16 to 18 hold remaining word bytes
// - hold bit freezes the synthesizer
// - apply bit self clears when frequency applied
`timescale 1ns/1ps
`include "adr_params.svh"
module adr_regs
  import adr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_synth_hold,
  output logic o_apply_pending,
  output logic o_osc_tick,
  output logic o_output_clock
);
  adr_regs_state_type state_reg;
  adr_regs_state_type state_next;

  adr_div_if chain_if();

  // the chain sees the applied copy plus the live hold bit, so half-written words never reach it
  assign chain_if.fast_code = state_reg.active_fast_code;
  assign chain_if.out_div = state_reg.active_out_div;
  assign chain_if.refword = state_reg.active_refword;
  assign chain_if.hold = state_reg.synth_hold_bit;

  adr_clock_chain u_chain (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .chain(chain_if.core)
  );

  // one offset decode serves the write path, the apply handshake and the read path
  function automatic adr_reg_sel_type reg_select(input logic [7:0] addr);
    if (addr == `ADR_OFS_DIV) begin
      reg_select = sel_div;
    end else if (addr == `ADR_OFS_DIV_LOW_TOP) begin
      reg_select = sel_div_low_top;
    end else if (addr == `ADR_OFS_REF_31_24) begin
      reg_select = sel_ref_31_24;
    end else if (addr == `ADR_OFS_REF_23_16) begin
      reg_select = sel_ref_23_16;
    end else if (addr == `ADR_OFS_REF_15_8) begin
      reg_select = sel_ref_15_8;
    end else if (addr == `ADR_OFS_REF_7_0) begin
      reg_select = sel_ref_7_0;
    end else if (addr == `ADR_OFS_CONTROL) begin
      reg_select = sel_control;
    end else if (addr == `ADR_OFS_HOLD) begin
      reg_select = sel_hold;
    end else begin
      reg_select = sel_none; // unmapped offsets
    end
  endfunction

  // register writes, then the apply handshake
  always_comb begin
    adr_reg_sel_type sel;
    sel = reg_select(i_reg_addr);
    state_next = state_reg;
    // tick pulses are re-timed here so every output leaves a flip-flop
    state_next.osc_tick = chain_if.osc_tick;
    state_next.out_tick = chain_if.out_tick;
    if (i_reg_wr) begin
      if (sel == sel_div) begin
        state_next.alt_fast_divider_code = i_reg_wdata[7:5];
        state_next.alt_output_divider_value[6:2] = i_reg_wdata[4:0];
      end else if (sel == sel_div_low_top) begin
        state_next.alt_output_divider_value[1:0] = i_reg_wdata[7:6];
        state_next.alt_reference_freq_word[37:32] = i_reg_wdata[5:0];
      end else if (sel == sel_ref_31_24) begin
        state_next.alt_reference_freq_word[31:24] = i_reg_wdata;
      end else if (sel == sel_ref_23_16) begin
        state_next.alt_reference_freq_word[23:16] = i_reg_wdata;
      end else if (sel == sel_ref_15_8) begin
        state_next.alt_reference_freq_word[15:8] = i_reg_wdata;
      end else if (sel == sel_ref_7_0) begin
        state_next.alt_reference_freq_word[7:0] = i_reg_wdata;
      end else if (sel == sel_hold) begin
        state_next.synth_hold_bit = i_reg_wdata[`ADR_HOLD_BIT];
      end
    end
    // a host write of the apply bit wins over the self clear in the same cycle
    if (i_reg_wr && sel == sel_control) begin
      state_next.apply_new_frequency_bit = i_reg_wdata[`ADR_APPLY_BIT];
    end else if (state_reg.apply_new_frequency_bit && !state_reg.synth_hold_bit) begin
      state_next.active_fast_code = state_reg.alt_fast_divider_code;
      state_next.active_out_div = state_reg.alt_output_divider_value;
      state_next.active_refword = state_reg.alt_reference_freq_word;
      state_next.apply_new_frequency_bit = 1'b0;
    end
    // registered read; unmapped offsets read zero
    if (i_reg_rd) begin
      if (sel == sel_div) begin
        state_next.rdata = {state_reg.alt_fast_divider_code,
                            state_reg.alt_output_divider_value[6:2]};
      end else if (sel == sel_div_low_top) begin
        state_next.rdata = {state_reg.alt_output_divider_value[1:0],
                            state_reg.alt_reference_freq_word[37:32]};
      end else if (sel == sel_ref_31_24) begin
        state_next.rdata = state_reg.alt_reference_freq_word[31:24];
      end else if (sel == sel_ref_23_16) begin
        state_next.rdata = state_reg.alt_reference_freq_word[23:16];
      end else if (sel == sel_ref_15_8) begin
        state_next.rdata = state_reg.alt_reference_freq_word[15:8];
      end else if (sel == sel_ref_7_0) begin
        state_next.rdata = state_reg.alt_reference_freq_word[7:0];
      end else if (sel == sel_control) begin
        state_next.rdata = `ADR_RST_BYTE;
        state_next.rdata[`ADR_APPLY_BIT] = state_reg.apply_new_frequency_bit;
      end else if (sel == sel_hold) begin
        state_next.rdata = `ADR_RST_BYTE;
        state_next.rdata[`ADR_HOLD_BIT] = state_reg.synth_hold_bit;
      end else begin
        state_next.rdata = `ADR_RST_BYTE;
      end
    end
  end

  // register the whole state; reset clears the shadow and the applied copy alike
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg.alt_fast_divider_code <= `ADR_RST_FAST_CODE;
      state_reg.alt_output_divider_value <= `ADR_RST_OUT_DIV;
      state_reg.alt_reference_freq_word <= `ADR_RST_REFWORD;
      state_reg.active_fast_code <= `ADR_RST_FAST_CODE;
      state_reg.active_out_div <= `ADR_RST_OUT_DIV;
      state_reg.active_refword <= `ADR_RST_REFWORD;
      state_reg.synth_hold_bit <= 1'b0;
      state_reg.apply_new_frequency_bit <= 1'b0;
      state_reg.rdata <= `ADR_RST_BYTE;
      state_reg.osc_tick <= 1'b0;
      state_reg.out_tick <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ports read the registered state directly
  assign o_reg_rdata = state_reg.rdata;
  assign o_synth_hold = state_reg.synth_hold_bit;
  assign o_apply_pending = state_reg.apply_new_frequency_bit;
  assign o_osc_tick = state_reg.osc_tick;
  assign o_output_clock = state_reg.out_tick;
endmodule

/* File: shared/adr_params.svh */
`ifndef ADR_PARAMS_SVH
`define ADR_PARAMS_SVH

// register offsets on the byte-wide register port
`define ADR_OFS_DIV 8'h0d
`define ADR_OFS_DIV_LOW_TOP 8'h0e
`define ADR_OFS_REF_31_24 8'h0f
`define ADR_OFS_REF_23_16 8'h10
`define ADR_OFS_REF_15_8 8'h11
`define ADR_OFS_REF_7_0 8'h12
`define ADR_OFS_CONTROL 8'h87
`define ADR_OFS_HOLD 8'h89

// field positions
`define ADR_APPLY_BIT 6
`define ADR_HOLD_BIT 4

// reset values
`define ADR_RST_FAST_CODE 3'h0
`define ADR_RST_OUT_DIV 7'h00
`define ADR_RST_REFWORD 38'h00_0000_0000
`define ADR_RST_BYTE 8'h00

`endif

/* File: shared/adr_pkg.sv */
package adr_pkg;
  typedef logic [2:0] adr_fast_code_type;
  typedef logic [6:0] adr_out_div_type;
  typedef logic [37:0] adr_refword_type;

  // state of the register bank
  typedef struct packed {
    adr_fast_code_type alt_fast_divider_code;
    adr_out_div_type alt_output_divider_value;
    adr_refword_type alt_reference_freq_word;
    adr_fast_code_type active_fast_code;
    adr_out_div_type active_out_div;
    adr_refword_type active_refword;
    logic synth_hold_bit;
    logic apply_new_frequency_bit;
    logic [7:0] rdata;
    logic osc_tick;
    logic out_tick;
  } adr_regs_state_type;

  // register picked by an offset; none stands for every unmapped offset
  typedef enum {
    sel_none,
    sel_div,
    sel_div_low_top,
    sel_ref_31_24,
    sel_ref_23_16,
    sel_ref_15_8,
    sel_ref_7_0,
    sel_control,
    sel_hold
  } adr_reg_sel_type;

  // state of the oscillator and divider chain
  typedef struct packed {
    adr_refword_type phase;
    logic [3:0] fast_count;
    logic [6:0] out_count;
    logic osc_tick;
    logic fast_tick;
    logic out_tick;
  } adr_chain_state_type;
endpackage

/* File: shared/adr_div_if.sv */
`timescale 1ns/1ps
interface adr_div_if;
  import adr_pkg::*;
  adr_fast_code_type fast_code;
  adr_out_div_type out_div;
  adr_refword_type refword;
  logic hold;
  logic osc_tick;
  logic out_tick;

  modport ctrl(output fast_code, output out_div, output refword, output hold,
               input osc_tick, input out_tick);
  modport core(input fast_code, input out_div, input refword, input hold,
               output osc_tick, output out_tick);
endinterface

/* File: rtl/adr_clock_chain.sv */
`timescale 1ns/1ps
module adr_clock_chain
  import adr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  adr_div_if.core chain
);
  adr_chain_state_type state_reg;
  adr_chain_state_type state_next;

  // ratio of the fast divider; zero marks the two codes with no ratio
  function automatic logic [3:0] fast_ratio(input adr_fast_code_type code);
    case (code)
      3'h0: fast_ratio = 4'h4;
      3'h1: fast_ratio = 4'h5;
      3'h2: fast_ratio = 4'h6;
      3'h3: fast_ratio = 4'h7;
      3'h5: fast_ratio = 4'h9;
      3'h7: fast_ratio = 4'hb;
      default: fast_ratio = 4'h0;
    endcase
  endfunction

  // last count of the output divider; odd ratios above one round up to even
  function automatic logic [6:0] out_limit(input adr_out_div_type value);
    if (value == 7'h00) begin
      out_limit = 7'h00;
    end else if (value[0]) begin
      out_limit = value;
    end else begin
      out_limit = 7'(value + 7'h01);
    end
  endfunction

  // the oscillator is a phase accumulator whose carry is one oscillator edge;
  // an undefined code stops the fast divider rather than guessing a ratio
  always_comb begin
    logic [38:0] sum;
    logic [3:0] ratio;
    sum = 39'h00_0000_0000;
    ratio = fast_ratio(chain.fast_code);
    state_next = state_reg;
    state_next.osc_tick = 1'b0;
    state_next.fast_tick = 1'b0;
    state_next.out_tick = 1'b0;
    if (!chain.hold) begin
      sum = {1'b0, state_reg.phase} + {1'b0, chain.refword};
      state_next.phase = sum[37:0];
      state_next.osc_tick = sum[38];
    end
    // fast divider counts oscillator edges only
    if (state_reg.osc_tick && ratio != 4'h0) begin
      if (state_reg.fast_count >= 4'(ratio - 4'h1)) begin
        state_next.fast_count = 4'h0;
        state_next.fast_tick = 1'b1;
      end else begin
        state_next.fast_count = 4'(state_reg.fast_count + 4'h1);
      end
    end
    // output divider counts fast divider edges
    if (state_reg.fast_tick) begin
      if (state_reg.out_count >= out_limit(chain.out_div)) begin
        state_next.out_count = 7'h00;
        state_next.out_tick = 1'b1;
      end else begin
        state_next.out_count = 7'(state_reg.out_count + 7'h01);
      end
    end
  end

  // reset clears the accumulator and both divider counts together
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // both ticks leave straight from the state flops
  assign chain.osc_tick = state_reg.osc_tick;
  assign chain.out_tick = state_reg.out_tick;
endmodule

/* File: tb/adr_host.sv */
`timescale 1ns/1ps
module adr_host (
  input wire logic i_clock,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  // port idle at time zero
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // one byte a cycle; enter 2 ns after an edge, strobes stay up for back to back use
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    o_reg_wr = wr;
    o_reg_rd = !wr;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_clock);
    #2;
  endtask
  // released data bus shows the inverse so stale bytes are never mistaken
  task automatic idle;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = ~o_reg_wdata;
  endtask
  // frozen update of a whole configuration, then apply while still frozen
  task automatic load(input logic [2:0] code, input int ratio, input logic [37:0] w);
    logic [6:0] v;
    v = 7'(ratio - 1);
    if (code == 3'h4 || code == 3'h6) code = 3'h0;
    xfer(1'b1, 8'h89, 8'h10);
    xfer(1'b1, 8'h0d, {code, v[6:2]});
    xfer(1'b1, 8'h0e, {v[1:0], w[37:32]});
    xfer(1'b1, 8'h0f, w[31:24]);
    xfer(1'b1, 8'h10, w[23:16]);
    xfer(1'b1, 8'h11, w[15:8]);
    xfer(1'b1, 8'h12, w[7:0]);
    xfer(1'b1, 8'h87, 8'h40);
  endtask
endmodule

/* File: tb/adr_regs_checker.sv */
`timescale 1ns/1ps
module adr_regs_checker (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_synth_hold,
  input wire logic o_apply_pending,
  input wire logic o_osc_tick,
  input wire logic o_output_clock
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // a configuration byte read right after its write returns that byte
  property p_back;
    i_reg_wr && i_reg_addr inside {[8'h0d:8'h12]} ##1 i_reg_rd && !i_reg_wr &&
      i_reg_addr == $past(i_reg_addr) |=> o_reg_rdata == $past(i_reg_wdata, 2);
  endproperty
  property p_unmap;
    i_reg_rd && i_reg_addr == 8'h20 |=> o_reg_rdata == 8'h00;
  endproperty
  // apply with no hold pulses exactly one cycle
  property p_apply;
    i_reg_wr && i_reg_addr == 8'h87 && i_reg_wdata[6] && !o_synth_hold
      |=> o_apply_pending ##1 !o_apply_pending;
  endproperty
  property p_held;
    o_synth_hold && o_apply_pending |=> o_apply_pending;
  endproperty
  property p_freeze;
    o_synth_hold [*3] |-> !o_osc_tick;
  endproperty
  property p_hold_wr;
    i_reg_wr && i_reg_addr == 8'h89 |=> o_synth_hold == $past(i_reg_wdata[4]);
  endproperty
  property p_apply_rd;
    i_reg_rd && !i_reg_wr && i_reg_addr == 8'h87
      |=> o_reg_rdata == {1'b0, $past(o_apply_pending), 6'h00};
  endproperty
  property p_hold_rd;
    i_reg_rd && !i_reg_wr && i_reg_addr == 8'h89
      |=> o_reg_rdata == {3'h0, $past(o_synth_hold), 4'h0};
  endproperty
  // smallest total ratio is four, so pulses are never closer
  property p_gap;
    o_output_clock |=> !o_output_clock [*3];
  endproperty
  a_back: assert property (p_back) else $error("readback differs");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_apply: assert property (p_apply) else $error("apply pulse wrong");
  a_held: assert property (p_held) else $error("apply cleared while held");
  a_freeze: assert property (p_freeze) else $error("tick while frozen");
  a_hold_wr: assert property (p_hold_wr) else $error("hold bit wrong");
  a_apply_rd: assert property (p_apply_rd) else $error("apply read wrong");
  a_hold_rd: assert property (p_hold_rd) else $error("hold read wrong");
  a_gap: assert property (p_gap) else $error("output pulses too close");
  c_apply: cover property (o_apply_pending ##1 !o_apply_pending);
  c_held: cover property (o_synth_hold && o_apply_pending);
  c_out: cover property (o_output_clock);
endmodule
bind adr_regs adr_regs_checker chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_synth_hold(o_synth_hold),
  .o_apply_pending(o_apply_pending), .o_osc_tick(o_osc_tick),
  .o_output_clock(o_output_clock));

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_reg_wr, i_reg_rd, o_synth_hold, o_apply_pending, o_osc_tick, o_output_clock;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [7:0] lfsr_reg = 8'h49;
  logic rd_seen = 1'b0;
  logic skip = 1'b0;
  logic [7:0] rd_q[$];
  int gap_q[$];
  int error_cnt = 0, comparisons = 0, ticks = 0;
  int codes[6] = '{0, 1, 2, 3, 5, 7};
  int ratios[6] = '{128, 10, 3, 2, 1, 1};
  int gaps[6] = '{512, 50, 24, 14, 9, 11};
  // 50 ns clock
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  adr_host host (.i_clock(i_clock), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
    .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
  adr_regs uut (.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_synth_hold(o_synth_hold),
    .o_apply_pending(o_apply_pending), .o_osc_tick(o_osc_tick),
    .o_output_clock(o_output_clock));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkgap(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // read data and output pulses are settled by the falling edge
  always @(posedge i_clock) rd_seen <= i_reg_rd;
  always @(negedge i_clock) begin
    if (rd_seen) check8(o_reg_rdata, rd_q.pop_front());
    if (o_output_clock === 1'b1) begin
      if (!skip && gap_q.size() > 0) checkgap(ticks + int'(o_osc_tick), gap_q.pop_front());
      skip = 1'b0;
      ticks = 0;
    end else ticks += int'(o_osc_tick === 1'b1);
  end
  initial begin
    repeat (4) @(posedge i_clock);
    #2 i_rst = 1'b0;
    for (int a = 13; a < 19; a++) rd(8'(a), 8'h00);
    for (int a = 13; a < 19; a++) begin
      lfsr_reg = lfsr(lfsr_reg);
      host.xfer(1'b1, 8'(a), lfsr_reg);
      rd(8'(a), lfsr_reg);
    end
    host.xfer(1'b1, 8'h20, lfsr_reg);
    rd(8'h20, 8'h00);
    host.xfer(1'b1, 8'h87, 8'h40);
    rd(8'h87, 8'h40);
    rd(8'h87, 8'h00);
    // each defined fast code with a divider value; ticks per output pulse is the product, ratio 3 counting as 4
    for (int i = 0; i < 6; i++) begin
      host.load(3'(codes[i]), ratios[i], 38'h3f_ffff_ffff);
      rd(8'h89, 8'h10);
      rd(8'h87, 8'h40);
      host.idle();
      repeat (4) @(posedge i_clock);
      skip = 1'b1;
      gap_q = '{gaps[i], gaps[i]};
      #2 host.xfer(1'b1, 8'h89, 8'h00);
      host.idle();
      for (int n = 0; n < 2000 && gap_q.size() > 0; n++) @(posedge i_clock);
      checkgap(gap_q.size(), 0);
      #2 rd(8'h87, 8'h00);
      host.idle();
    end
    repeat (3) @(posedge i_clock);
    finish_test;
  end
  // the run needs about 2000 cycles
  initial begin
    #500000;
    error_cnt++;
    finish_test;
  end
endmodule
